// file: rtl/mrsc_consts.svh
// Purpose: constants of the MIDI receive and sync control block
// Assumes: 40 MHz system clock
// Notes:   data values are 7-bit MIDI data bytes
`ifndef MRSC_CONSTS_SVH
`define MRSC_CONSTS_SVH

`define MRSC_CLK_HZ          40000000
`define MRSC_NOTE_LO         7'h12
`define MRSC_NOTE_HI         7'h4B
`define MRSC_NOTE_ENV        7'h00
`define MRSC_HALF            7'h40
`define MRSC_CC_CUTOFF       7'h4A
`define MRSC_CC_ENV          7'h50
`define MRSC_PROG_MAX        7'h0F
`define MRSC_ST_NOTE_OFF     4'h8
`define MRSC_ST_NOTE_ON      4'h9
`define MRSC_ST_CC           4'hB
`define MRSC_ST_PC           4'hC
`define MRSC_ST_CHPRESS      4'hD
`define MRSC_RT_CLOCK        8'hF8
`define MRSC_RT_START        8'hFA
`define MRSC_RT_CONT         8'hFB
`define MRSC_RT_STOP         8'hFC
`define MRSC_SX_START        8'hF0
`define MRSC_SX_END          8'hF7
`define MRSC_SX_TYPE_BANK    7'h01
`define MRSC_SX_TYPE_STATE   7'h02
`define MRSC_CHAN_RST        4'h0
`define MRSC_CLK_TIMEOUT_MS  100
`define MRSC_CLK_TIMEOUT_CYC (`MRSC_CLK_TIMEOUT_MS * (`MRSC_CLK_HZ / 1000))
`define MRSC_INT_TICK_CYC    833333

`endif

// file: rtl/mrsc_pkg.sv
// Purpose: types of the MIDI receive and sync control block
// Assumes: constants live in mrsc_consts.svh
// Notes:   none
package mrsc_pkg;

  typedef enum logic [1:0] {SRC_INT, SRC_MIDI, SRC_DIN} mrsc_src_e;
  typedef enum logic [1:0] {LOCK_NONE, LOCK_DIN, LOCK_USB} mrsc_lock_e;

  typedef struct packed {
    logic       vld;
    logic [7:0] st;
    logic [6:0] d1;
    logic [6:0] d2;
  } mrsc_msg_s;

  typedef struct packed {
    mrsc_src_e  sync_sel;
    logic [3:0] receive_channel;
    logic [3:0] transmit_channel;
    logic       usb_en;
    logic       clk_out_en;
    logic       pc_rx_en;
    logic       pc_tx_en;
  } mrsc_cfg_s;

  typedef struct packed {
    logic       vld;
    logic [3:0] chan;
    logic [6:0] prog;
    logic       usb;
  } mrsc_pc_s;

  typedef struct packed {
    logic       vld;
    logic       state;
    logic [2:0] bank;
    logic       usb;
  } mrsc_dump_s;

  typedef struct packed {
    logic       vld;
    logic       full;
    logic [2:0] bank;
    logic [6:0] data;
  } mrsc_mem_s;

endpackage : mrsc_pkg

// file: rtl/mrsc_top.sv
// Purpose: MIDI receive interpreter and sequencer sync control
// Assumes: byte streams come from UART/USB logic on clk_in; sync pins are async
// Notes:   one message is interpreted per cycle, DIN first
// Function
// - accept pitches 18..75; note overlapping a held note plays as slide
// - velocity 0..63 no accent, 64..127 accent
// - controller 74 value sets filter cutoff
// - note number 0 triggers modulation envelope
// - controller 80 high fires once; re-armed only by a low value
// - sync source internal, MIDI or five-pin; MIDI by default
// - under MIDI sync, Start or Continue starts playback
// - after Start, tempo follows MIDI timing clock
// - Stop returns tempo to internal clock without halting
// - internal tempo generator always runs; local run works anytime
// - Start while running switches to MIDI clock without stopping
// - Start during playback restarts pattern at first step
// - merge DIN and USB clock; lock first source, switch when it stops
// - five-pin sync clock always out; MIDI clock out switchable
// - separate receive and transmit channels 1..16
// - with USB enabled, SysEx and program change go out on USB
// - program 1..16 selects pattern in bank; others ignored
// - optionally send program change on pattern change
// - bank send dumps the currently selected bank
// - received bank dump goes to the bank it came from
// - machine-state dump overwrites everything
`timescale 1ns/10ps
`include "mrsc_consts.svh"

module mrsc_top #(
  parameter int CLK_TIMEOUT_CYC = `MRSC_CLK_TIMEOUT_CYC,
  parameter int INT_TICK_CYC    = `MRSC_INT_TICK_CYC
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic [7:0]       din_byte_in,
  input  wire logic             din_vld_in,
  output logic                  din_rdy_out,
  input  wire logic [7:0]       usb_byte_in,
  input  wire logic             usb_vld_in,
  output logic                  usb_rdy_out,
  input  wire mrsc_pkg::mrsc_cfg_s cfg_in,
  input  wire logic             cfg_load_in,
  input  wire logic             run_btn_in,
  input  wire logic             pat_load_in,
  input  wire logic [3:0]       pat_in,
  input  wire logic             bank_send_in,
  input  wire logic             state_send_in,
  input  wire logic [2:0]       bank_in,
  input  wire logic             sync_clk_pin_in,
  input  wire logic             sync_run_pin_in,
  output mrsc_pkg::mrsc_cfg_s   cfg_out,
  output logic [6:0]            note_out,
  output logic                  gate_out,
  output logic                  accent_out,
  output logic                  slide_out,
  output logic                  note_strobe_out,
  output logic                  env_trig_out,
  output logic [6:0]            cutoff_out,
  output logic [3:0]            pattern_out,
  output logic                  running_out,
  output mrsc_pkg::mrsc_src_e   tempo_src_out,
  output logic                  seq_tick_out,
  output logic                  restart_out,
  output logic                  sync_clk_out,
  output logic                  midi_clk_tx_out,
  output mrsc_pkg::mrsc_pc_s    pc_tx_out,
  output mrsc_pkg::mrsc_dump_s  dump_send_out,
  output mrsc_pkg::mrsc_mem_s   mem_wr_out
);

  function automatic logic two_data(input logic [7:0] st);
    two_data = (st[7:4] != `MRSC_ST_PC) && (st[7:4] != `MRSC_ST_CHPRESS);
  endfunction : two_data
  function automatic logic is_chan(input logic [7:0] st, input logic [3:0] hi,
                                   input logic [3:0] ch);
    is_chan = (st[7:4] == hi) && (st[3:0] == ch);
  endfunction : is_chan
  // byte parsers, one per source; each holds one finished message
  logic [7:0]        src_byte [2];
  logic              src_vld  [2];
  logic              free     [2];
  logic              take     [2];
  mrsc_pkg::mrsc_msg_s pend   [2];
  assign src_byte[0] = din_byte_in;
  assign src_byte[1] = usb_byte_in;
  assign src_vld[0]  = din_vld_in;
  assign src_vld[1]  = usb_vld_in;
  assign din_rdy_out = free[0];
  assign usb_rdy_out = free[1];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_parse
      logic [7:0] run_st;
      logic [6:0] db;
      logic       have;
      logic [1:0] sx;
      wire        acc  = src_vld[g] && free[g];
      wire  [7:0] b    = src_byte[g];
      // usb bytes are drained but dropped while USB MIDI is off
      wire        keep = (g == 0) || cfg_out.usb_en;
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          run_st <= 8'h00;
          db     <= 7'h00;
          have   <= 1'b0;
          sx     <= 2'h0;
          free[g] <= 1'b1;
          pend[g] <= '0;
        end else begin
          if (take[g]) begin
            free[g] <= 1'b1;
          end
          if (acc) begin
            if (b[7] && b >= `MRSC_RT_CLOCK) begin
              pend[g] <= '{1'b1, b, 7'h00, 7'h00};
              free[g] <= !keep;
            end else if (b == `MRSC_SX_START) begin
              sx     <= 2'h1;
              run_st <= 8'h00;
            end else if (b[7]) begin
              if (sx != 2'h0 && b == `MRSC_SX_END) begin
                pend[g] <= '{1'b1, b, 7'h00, 7'h00};
                free[g] <= !keep;
              end
              sx     <= 2'h0;
              have   <= 1'b0;
              run_st <= (b < `MRSC_SX_START) ? b : 8'h00;
            end else if (sx != 2'h0) begin
              pend[g] <= '{1'b1, `MRSC_SX_START, b[6:0], {5'h00, sx}};
              free[g] <= !keep;
              sx      <= (sx == 2'h3) ? sx : sx + 2'h1;
            end else if (run_st != 8'h00) begin
              if (two_data(run_st) && !have) begin
                db   <= b[6:0];
                have <= 1'b1;
              end else begin
                pend[g] <= '{1'b1, run_st, two_data(run_st) ? db : b[6:0], b[6:0]};
                free[g] <= !keep;
                have    <= 1'b0;
              end
            end
          end
        end
      end
    end
  endgenerate
  // arbiter: DIN message first, USB waits one cycle
  wire  sel_usb = free[0];
  assign take[0] = !free[0];
  assign take[1] = free[0] && !free[1];
  mrsc_pkg::mrsc_msg_s m;
  assign m = sel_usb ? (free[1] ? '0 : pend[1]) : pend[0];
  // message classes
  wire [3:0] rxc     = cfg_out.receive_channel;
  wire       on_msg  = m.vld && is_chan(m.st, `MRSC_ST_NOTE_ON, rxc);
  wire       off_msg = m.vld && (is_chan(m.st, `MRSC_ST_NOTE_OFF, rxc)
                                 || (on_msg && m.d2 == 7'h00));
  wire       note_on = on_msg && m.d2 != 7'h00;
  wire       in_rng  = m.d1 >= `MRSC_NOTE_LO && m.d1 <= `MRSC_NOTE_HI;
  wire       note_go = note_on && in_rng;
  wire       env_nt  = note_on && m.d1 == `MRSC_NOTE_ENV;
  wire       cc      = m.vld && is_chan(m.st, `MRSC_ST_CC, rxc);
  wire       cc_cut  = cc && m.d1 == `MRSC_CC_CUTOFF;
  wire       cc_env  = cc && m.d1 == `MRSC_CC_ENV;
  wire       pc_ok   = m.vld && is_chan(m.st, `MRSC_ST_PC, rxc)
                       && cfg_out.pc_rx_en && m.d1 <= `MRSC_PROG_MAX;
  wire       sx_dat  = m.vld && m.st == `MRSC_SX_START;
  wire       rt_start = m.vld && m.st == `MRSC_RT_START;
  wire       rt_cont  = m.vld && m.st == `MRSC_RT_CONT;
  wire       rt_stop  = m.vld && m.st == `MRSC_RT_STOP;
  wire       rt_clk   = m.vld && m.st == `MRSC_RT_CLOCK;
  wire       sel_midi = cfg_out.sync_sel == mrsc_pkg::SRC_MIDI;
  wire       sel_din  = cfg_out.sync_sel == mrsc_pkg::SRC_DIN;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_out <= '{mrsc_pkg::SRC_MIDI, `MRSC_CHAN_RST, `MRSC_CHAN_RST,
                   1'b0, 1'b0, 1'b0, 1'b0};
    end else if (cfg_load_in) begin
      cfg_out <= cfg_in;
    end
  end
  // voice
  logic env_arm;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      note_out        <= `MRSC_NOTE_LO;
      gate_out        <= 1'b0;
      accent_out      <= 1'b0;
      slide_out       <= 1'b0;
      note_strobe_out <= 1'b0;
      env_trig_out    <= 1'b0;
      env_arm         <= 1'b1;
      cutoff_out      <= 7'h00;
    end else begin
      note_strobe_out <= note_go;
      if (note_go) begin
        note_out   <= m.d1;
        gate_out   <= 1'b1;
        slide_out  <= gate_out;
        accent_out <= m.d2 >= `MRSC_HALF;
      end else if (off_msg && m.d1 == note_out) begin
        gate_out <= 1'b0;
      end
      if (cc_cut) begin
        cutoff_out <= m.d2;
      end
      if (cc_env) begin
        env_arm <= m.d2 < `MRSC_HALF;
      end
      env_trig_out <= env_nt || (cc_env && env_arm && m.d2 >= `MRSC_HALF);
    end
  end
  // clock merge: first source locks, other is discarded until timeout
  mrsc_pkg::mrsc_lock_e lock;
  logic [31:0]          lock_cnt;
  wire  this_src = sel_usb ? (lock == mrsc_pkg::LOCK_USB) : (lock == mrsc_pkg::LOCK_DIN);
  wire  clk_ok   = rt_clk && (lock == mrsc_pkg::LOCK_NONE || this_src);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock     <= mrsc_pkg::LOCK_NONE;
      lock_cnt <= 32'h0;
    end else if (clk_ok) begin
      lock     <= sel_usb ? mrsc_pkg::LOCK_USB : mrsc_pkg::LOCK_DIN;
      lock_cnt <= 32'h0;
    end else if (lock != mrsc_pkg::LOCK_NONE) begin
      if (lock_cnt >= 32'(CLK_TIMEOUT_CYC - 1)) begin
        lock <= mrsc_pkg::LOCK_NONE;
      end
      lock_cnt <= lock_cnt + 32'h1;
    end
  end
  // internal tempo, never stopped
  logic [31:0] int_cnt;
  wire         int_tick = int_cnt == 32'(INT_TICK_CYC - 1);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_cnt <= 32'h0;
    end else begin
      int_cnt <= int_tick ? 32'h0 : int_cnt + 32'h1;
    end
  end
  // five-pin link inputs: two flops before use
  logic [1:0] clk_sy;
  logic [1:0] run_sy;
  logic       clk_d;
  logic       run_d;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_sy <= 2'h0;
      run_sy <= 2'h0;
      clk_d  <= 1'b0;
      run_d  <= 1'b0;
    end else begin
      clk_sy <= {clk_sy[0], sync_clk_pin_in};
      run_sy <= {run_sy[0], sync_run_pin_in};
      clk_d  <= clk_sy[1];
      run_d  <= run_sy[1];
    end
  end
  wire din_tick = clk_sy[1] && !clk_d;
  wire din_rise = sel_din && run_sy[1] && !run_d;
  wire din_fall = sel_din && !run_sy[1] && run_d;
  // sequencer run state and tempo source
  wire midi_go   = sel_midi && (rt_start || rt_cont);
  wire midi_rst  = sel_midi && rt_start && running_out;
  wire tick_any  = (tempo_src_out == mrsc_pkg::SRC_MIDI) ? clk_ok :
                   (tempo_src_out == mrsc_pkg::SRC_DIN)  ? din_tick : int_tick;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      running_out     <= 1'b0;
      tempo_src_out   <= mrsc_pkg::SRC_INT;
      seq_tick_out    <= 1'b0;
      restart_out     <= 1'b0;
      sync_clk_out    <= 1'b0;
      midi_clk_tx_out <= 1'b0;
    end else begin
      restart_out     <= midi_rst || din_rise;
      seq_tick_out    <= running_out && tick_any;
      sync_clk_out    <= tick_any;
      midi_clk_tx_out <= tick_any && cfg_out.clk_out_en;
      if (midi_go || din_rise) begin
        running_out <= 1'b1;
      end else if (run_btn_in) begin
        running_out <= !running_out;
      end
      if (sel_midi && rt_start) begin
        tempo_src_out <= mrsc_pkg::SRC_MIDI;
      end else if (din_rise) begin
        tempo_src_out <= mrsc_pkg::SRC_DIN;
      end else if ((sel_midi && rt_stop) || din_fall || !cfg_out.sync_sel[1] && !sel_midi) begin
        tempo_src_out <= mrsc_pkg::SRC_INT;
      end
    end
  end
  // patterns, program change out, dumps
  wire       pat_chg = pc_ok || pat_load_in;
  wire [3:0] pat_new = pc_ok ? m.d1[3:0] : pat_in;
  logic       sx_full;
  logic [2:0] sx_bank;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pattern_out   <= 4'h0;
      pc_tx_out     <= '0;
      dump_send_out <= '0;
      mem_wr_out    <= '0;
      sx_full       <= 1'b0;
      sx_bank       <= 3'h0;
    end else begin
      if (pat_chg) begin
        pattern_out <= pat_new;
      end
      pc_tx_out <= '{pat_chg && pat_new != pattern_out && cfg_out.pc_tx_en,
                     cfg_out.transmit_channel, {3'h0, pat_new},
                     cfg_out.usb_en};
      dump_send_out <= '{bank_send_in || state_send_in, state_send_in,
                         bank_in, cfg_out.usb_en};
      mem_wr_out.vld <= 1'b0;
      if (sx_dat && m.d2 == 7'h01) begin
        sx_full <= m.d1 == `MRSC_SX_TYPE_STATE;
      end else if (sx_dat && m.d2 == 7'h02 && !sx_full) begin
        sx_bank <= m.d1[2:0];
      end else if (sx_dat) begin
        mem_wr_out <= '{1'b1, sx_full, sx_bank, m.d1};
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_start_midi;
    sel_midi && rt_start;
  endsequence
  sequence s_stop_midi;
    sel_midi && rt_stop && !rt_start;
  endsequence

  AST_NOTE_RANGE: assert property (note_strobe_out |->
    note_out >= `MRSC_NOTE_LO && note_out <= `MRSC_NOTE_HI)
    else $error("note outside accepted range");
  AST_SLIDE: assert property (note_go |=> slide_out == $past(gate_out))
    else $error("slide not tied to held note");
  AST_ACCENT: assert property (note_go |=> accent_out == $past(m.d2[6]))
    else $error("accent does not follow velocity");
  AST_CUTOFF: assert property (cc_cut |=> cutoff_out == $past(m.d2))
    else $error("cutoff not taken from controller");
  AST_ENV_NOTE: assert property (env_nt |=> env_trig_out)
    else $error("note zero did not trigger envelope");
  AST_CC80_ONCE: assert property (cc_env && !env_arm && !env_nt |=> !env_trig_out)
    else $error("envelope fired without re-arm");
  AST_START: assert property (s_start_midi |=>
    running_out && tempo_src_out == mrsc_pkg::SRC_MIDI)
    else $error("start did not run on MIDI clock");
  AST_RESTART: assert property (s_start_midi ##0 running_out |=> restart_out)
    else $error("start while running did not restart");
  AST_STOP: assert property (s_stop_midi ##0 !run_btn_in |=>
    $stable(running_out) && tempo_src_out == mrsc_pkg::SRC_INT)
    else $error("stop changed run state or kept MIDI tempo");
  AST_PC_IGNORE: assert property (m.vld && m.st[7:4] == `MRSC_ST_PC
    && m.d1 > `MRSC_PROG_MAX && !pat_load_in |=> $stable(pattern_out))
    else $error("out of range program changed pattern");

endmodule : mrsc_top

// file: tb/mrsc_midi_src.sv
// Purpose: far-side MIDI source feeding the DIN and USB byte streams
// Assumes: byte taken on a rising edge with vld and rdy high
// Notes:   drives at falling edges; gap sets how slowly bytes follow
`timescale 1ns/10ps

module mrsc_midi_src (
  input  wire logic       clk_in,
  input  wire logic       din_rdy_in,
  input  wire logic       usb_rdy_in,
  output logic [7:0]      din_byte_out,
  output logic            din_vld_out,
  output logic [7:0]      usb_byte_out,
  output logic            usb_vld_out
);
  int gap = 0;

  initial begin
    din_byte_out = 8'hA5;
    usb_byte_out = 8'h5A;
    din_vld_out  = 1'b0;
    usb_vld_out  = 1'b0;
  end

  // rdy is a flop, so its value at the falling edge is what the next edge sees
  task automatic send(input logic [7:0] b, input logic usb, output bit ok);
    int n;
    ok = 1'b0;
    repeat (gap + 1) @(negedge clk_in);
    if (usb) begin
      usb_byte_out = b;
      usb_vld_out  = 1'b1;
    end else begin
      din_byte_out = b;
      din_vld_out  = 1'b1;
    end
    for (n = 0; n < 64 && !ok; n++) begin
      ok = usb ? (usb_rdy_in === 1'b1) : (din_rdy_in === 1'b1);
      @(negedge clk_in);
    end
    // released line shows the inverse, never a stale copy
    if (usb) begin
      usb_vld_out  = 1'b0;
      usb_byte_out = ~b;
    end else begin
      din_vld_out  = 1'b0;
      din_byte_out = ~b;
    end
  endtask : send
endmodule : mrsc_midi_src

// file: tb/midi_receive_and_sync_control_tb.sv
// Purpose: self-checking bench of the MIDI receive and sync control block
// Assumes: short tick and clock-loss counts set through parameters
// Notes:   pulse outputs are counted by a monitor and compared as deltas
`timescale 1ns/10ps

module midi_receive_and_sync_control_tb;
  localparam int STR = 0, ENV = 1, RST = 2, TCK = 3, SCK = 4, MTX = 5, PC = 6, DMP = 7, MEM = 8;
  logic        clk_in = 1'b0, nrst_in = 1'b0;
  logic [7:0]  din_byte_in, usb_byte_in;
  logic        din_vld_in, usb_vld_in, din_rdy_out, usb_rdy_out;
  logic        cfg_load_in = 1'b0, run_btn_in = 1'b0, pat_load_in = 1'b0;
  logic        bank_send_in = 1'b0, state_send_in = 1'b0;
  logic        sync_clk_pin_in = 1'b0, sync_run_pin_in = 1'b0;
  logic [3:0]  pat_in = 4'h0, pattern_out;
  logic [2:0]  bank_in = 3'h0;
  logic [6:0]  note_out, cutoff_out, en;
  logic        gate_out, accent_out, slide_out, note_strobe_out, env_trig_out;
  logic        running_out, seq_tick_out, restart_out, sync_clk_out, midi_clk_tx_out;
  mrsc_pkg::mrsc_cfg_s  cfg_in, cfg_out, ec;
  mrsc_pkg::mrsc_src_e  tempo_src_out;
  mrsc_pkg::mrsc_pc_s   pc_tx_out, lpc;
  mrsc_pkg::mrsc_dump_s dump_send_out, ldmp;
  mrsc_pkg::mrsc_mem_s  mem_wr_out, lmem;
  int          err_total = 0, num_checks = 0, i;
  int          cnt[9] = '{default: 0}, snap[9];
  // status, note, velocity, accepted, accent, slide
  logic [26:0] nt[6] = '{{8'h92, 8'h3C, 8'h50, 3'b110}, {8'h92, 8'h12, 8'h3F, 3'b101},
                         {8'h92, 8'h11, 8'h7F, 3'b001}, {8'h92, 8'h4B, 8'h40, 3'b111},
                         {8'h92, 8'h4C, 8'h40, 3'b011}, {8'h91, 8'h20, 8'h40, 3'b011}};
  // bit 7 is whether the value fires the envelope
  logic [7:0]  ev[6] = '{8'hC0, 8'h7F, 8'h3F, 8'hFF, 8'h00, 8'hFF};
  logic [7:0]  sx[10] = '{8'hF0, 8'h01, 8'h02, 8'h11, 8'h22, 8'hF7, 8'hF0, 8'h02, 8'h33, 8'hF7};

  mrsc_top #(.CLK_TIMEOUT_CYC(50), .INT_TICK_CYC(20)) dut (
    .clk_in, .nrst_in, .din_byte_in, .din_vld_in, .din_rdy_out, .usb_byte_in, .usb_vld_in,
    .usb_rdy_out, .cfg_in, .cfg_load_in, .run_btn_in, .pat_load_in, .pat_in, .bank_send_in,
    .state_send_in, .bank_in, .sync_clk_pin_in, .sync_run_pin_in, .cfg_out, .note_out,
    .gate_out, .accent_out, .slide_out, .note_strobe_out, .env_trig_out, .cutoff_out,
    .pattern_out, .running_out, .tempo_src_out, .seq_tick_out, .restart_out, .sync_clk_out,
    .midi_clk_tx_out, .pc_tx_out, .dump_send_out, .mem_wr_out);

  mrsc_midi_src src (.clk_in, .din_rdy_in(din_rdy_out), .usb_rdy_in(usb_rdy_out),
    .din_byte_out(din_byte_in), .din_vld_out(din_vld_in), .usb_byte_out(usb_byte_in),
    .usb_vld_out(usb_vld_in));

  always #12.5 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cnt[STR] += int'(note_strobe_out === 1'b1);
    cnt[ENV] += int'(env_trig_out === 1'b1);
    cnt[RST] += int'(restart_out === 1'b1);
    cnt[TCK] += int'(seq_tick_out === 1'b1);
    cnt[SCK] += int'(sync_clk_out === 1'b1);
    cnt[MTX] += int'(midi_clk_tx_out === 1'b1);
    if (pc_tx_out.vld === 1'b1) begin
      cnt[PC]++;
      lpc = pc_tx_out;
    end
    if (dump_send_out.vld === 1'b1) begin
      cnt[DMP]++;
      ldmp = dump_send_out;
    end
    if (mem_wr_out.vld === 1'b1) begin
      cnt[MEM]++;
      lmem = mem_wr_out;
    end
  end

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", s, e, g);
    end
  endtask : chk

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task tx(input logic [7:0] v, input logic u);
    bit ok;
    src.send(v, u, ok);
    chk("byte taken", 1, ok);
    if (!ok) begin
      final_report();
    end
  endtask : tx

  // output lands two or three edges after the last byte
  task msg(input logic [7:0] s, input logic [7:0] d1, input logic [7:0] d2, input logic u,
           input int n);
    tx(s, u);
    if (n > 1) tx(d1, u);
    if (n > 2) tx(d2, u);
    repeat (4) @(negedge clk_in);
  endtask : msg

  task automatic pulse(ref logic p);
    @(negedge clk_in);
    p = 1'b1;
    @(negedge clk_in);
    p = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : pulse

  task load(input mrsc_pkg::mrsc_src_e s, input logic ce);
    cfg_in = '{sync_sel: s, receive_channel: 4'h2, transmit_channel: 4'h5, usb_en: 1'b1,
               clk_out_en: ce, pc_rx_en: 1'b1, pc_tx_en: 1'b1};
    pulse(cfg_load_in);
    chk("cfg", 32'(cfg_in), 32'(cfg_out));
  endtask : load

  initial begin
    repeat (20000) @(posedge clk_in);
    chk("run finished", 1, 0);
    final_report();
  end

  initial begin
    cfg_in = '0;
    repeat (16) @(negedge clk_in);
    nrst_in = 1'b1;
    @(negedge clk_in);
    ec = '0;
    ec.sync_sel = mrsc_pkg::SRC_MIDI;
    chk("cfg reset", 32'(ec), 32'(cfg_out));
    chk("tempo reset", mrsc_pkg::SRC_INT, tempo_src_out);
    load(mrsc_pkg::SRC_MIDI, 1'b1);
    // notes only while the sequencer is stopped
    for (i = 0; i < 6; i++) begin
      snap = cnt;
      msg(nt[i][26:19], nt[i][18:11], nt[i][10:3], 1'b0, 3);
      if (nt[i][2]) en = nt[i][17:11];
      chk("strobe", snap[STR] + nt[i][2], cnt[STR]);
      chk("note", en, note_out);
      chk("accent", nt[i][1], accent_out);
      chk("slide", nt[i][0], slide_out);
    end
    chk("gate held", 1, gate_out);
    msg(8'h82, 8'h3C, 8'h00, 1'b0, 3);
    chk("gate other off", 1, gate_out);
    msg(8'h92, 8'h4B, 8'h00, 1'b0, 3);
    chk("gate off", 0, gate_out);
    msg(8'h92, 8'h30, 8'h40, 1'b0, 3);
    chk("no slide", 0, slide_out);
    snap = cnt;
    msg(8'h92, 8'h00, 8'h40, 1'b0, 3);
    chk("env note", snap[ENV] + 1, cnt[ENV]);
    // last pair is a momentary press, low then high
    for (i = 0; i < 6; i++) begin
      snap = cnt;
      msg(8'hB2, 8'h50, {1'b0, ev[i][6:0]}, 1'b0, 3);
      chk("env cc", snap[ENV] + ev[i][7], cnt[ENV]);
    end
    msg(8'hB2, 8'h4A, 8'h55, 1'b1, 3);
    chk("cutoff", 7'h55, cutoff_out);
    snap = cnt;
    msg(8'hC2, 8'h05, 8'h00, 1'b0, 2);
    chk("pattern", 4'h5, pattern_out);
    chk("pc out", {1'b1, 4'h5, 7'h05, 1'b1}, 32'(lpc));
    msg(8'hC2, 8'h10, 8'h00, 1'b0, 2);
    chk("pattern kept", 4'h5, pattern_out);
    chk("pc count", snap[PC] + 1, cnt[PC]);
    pat_in = 4'h9;
    pulse(pat_load_in);
    chk("pc local", 7'h09, lpc.prog);
    msg(8'hFA, 8'h00, 8'h00, 1'b0, 1);
    chk("start run", 1, running_out);
    chk("start src", mrsc_pkg::SRC_MIDI, tempo_src_out);
    snap = cnt;
    msg(8'hF8, 8'h00, 8'h00, 1'b0, 1);
    msg(8'hF8, 8'h00, 8'h00, 1'b1, 1);
    chk("midi ticks", snap[TCK] + 1, cnt[TCK]);
    chk("sync out", snap[SCK] + 1, cnt[SCK]);
    chk("midi out", snap[MTX] + 1, cnt[MTX]);
    msg(8'hFA, 8'h00, 8'h00, 1'b0, 1);
    chk("restart", snap[RST] + 1, cnt[RST]);
    msg(8'hFC, 8'h00, 8'h00, 1'b0, 1);
    chk("stop src", mrsc_pkg::SRC_INT, tempo_src_out);
    chk("stop run", 1, running_out);
    snap = cnt;
    repeat (100) @(negedge clk_in);
    chk("int ticks", 1, (cnt[TCK] - snap[TCK]) inside {[4:6]});
    msg(8'hFA, 8'h00, 8'h00, 1'b1, 1);
    snap = cnt;
    msg(8'hF8, 8'h00, 8'h00, 1'b1, 1);
    msg(8'hF8, 8'h00, 8'h00, 1'b0, 1);
    chk("usb lock", snap[TCK] + 1, cnt[TCK]);
    load(mrsc_pkg::SRC_MIDI, 1'b0);
    snap = cnt;
    msg(8'hF8, 8'h00, 8'h00, 1'b1, 1);
    chk("sync always", snap[SCK] + 1, cnt[SCK]);
    chk("midi gated", snap[MTX], cnt[MTX]);
    pulse(run_btn_in);
    chk("run button", 0, running_out);
    msg(8'hFB, 8'h00, 8'h00, 1'b0, 1);
    chk("continue", 1, running_out);
    bank_in = 3'h3;
    pulse(bank_send_in);
    chk("bank dump", {1'b1, 1'b0, 3'h3, 1'b1}, 32'(ldmp));
    pulse(state_send_in);
    chk("state dump", 1, ldmp.state);
    src.gap = 3;
    snap = cnt;
    for (i = 0; i < 6; i++) tx(sx[i], 1'b0);
    repeat (4) @(negedge clk_in);
    chk("bank rx", snap[MEM] + 2, cnt[MEM]);
    chk("bank rx word", {1'b1, 1'b0, 3'h2, 7'h22}, 32'(lmem));
    for (i = 6; i < 10; i++) tx(sx[i], 1'b0);
    repeat (4) @(negedge clk_in);
    chk("state rx word", {1'b1, 1'b1, 3'h2, 7'h33} & 12'hC7F, 32'(lmem) & 12'hC7F);
    src.gap = 0;
    load(mrsc_pkg::SRC_DIN, 1'b1);
    sync_run_pin_in = 1'b1;
    repeat (6) @(negedge clk_in);
    chk("pin src", mrsc_pkg::SRC_DIN, tempo_src_out);
    snap = cnt;
    for (i = 0; i < 3; i++) begin
      sync_clk_pin_in = 1'b1;
      repeat (3) @(negedge clk_in);
      sync_clk_pin_in = 1'b0;
      repeat (3) @(negedge clk_in);
    end
    chk("pin clock", snap[SCK] + 3, cnt[SCK]);
    chk("pin ticks", snap[TCK] + 3, cnt[TCK]);
    sync_run_pin_in = 1'b0;
    repeat (6) @(negedge clk_in);
    chk("pin stop", mrsc_pkg::SRC_INT, tempo_src_out);
    load(mrsc_pkg::SRC_INT, 1'b1);
    snap = cnt;
    msg(8'hFA, 8'h00, 8'h00, 1'b0, 1);
    chk("int sel", mrsc_pkg::SRC_INT, tempo_src_out);
    chk("int no restart", snap[RST], cnt[RST]);
    final_report();
  end
endmodule : midi_receive_and_sync_control_tb
